// ---- css_pkg.sv ----
`default_nettype none
package css_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_MHZ           = 250;
  localparam int unsigned SLOW_RATE_KHZ     = 2500;
  // Slow default configuration clock: mclk cycles per half period, rounded down
  localparam int unsigned SLOW_HALF_CYC     = (CLK_MHZ * 1000) / (2 * SLOW_RATE_KHZ);
  localparam int unsigned CLEAR_FRAMES_DFLT = 16;
  localparam int unsigned FRAME_BITS_DFLT   = 32;
  localparam int unsigned FRAME_CNT_DFLT    = 8;

  // ------------------------------------------------------------
  // Start-up stage positions
  // ------------------------------------------------------------
  localparam logic [2:0] POS_FLOAT_DFLT = 3'h1;
  localparam logic [2:0] POS_RESET_DFLT = 3'h2;
  localparam logic [2:0] POS_STORE_DFLT = 3'h2;
  localparam logic [2:0] POS_LAST       = 3'h7;

  typedef enum logic [2:0] {
    CSS_CLEAR,
    CSS_HOLD,
    CSS_LOAD,
    CSS_START,
    CSS_RUN
  } css_state_t;

  // Start-up options, sampled while loading
  typedef struct packed {
    logic [2:0] pos_float;
    logic [2:0] pos_reset;
    logic [2:0] pos_store;
    logic       wait_done;
    logic       wait_lock;
    logic [2:0] lock_stage;
  } css_opt_t;

  // Global controls, high while asserted
  typedef struct packed {
    logic output_float;
    logic state_reset;
    logic store_block;
  } css_glob_t;

endpackage : css_pkg
`default_nettype wire

// ---- css_sequencer.sv ----
`default_nettype none
// Overview of operation
// - Clear memory, then load frames, then run start-up, strictly in order.
// - Sequence starts by itself after reset; a low status pin only delays loading.
// - Low reconfiguration request restarts the sequence from memory clearing.
// - Status pin driven low while clearing, released when clearing ends.
// - Finish pin rises only after clearing and loading complete, as start-up begins.
// - Status pin is open-drain: only pulled low, never driven high.
// - After clearing, wait while status pin reads low before loading.
// - Default: output-float released one clock after finish rises.
// - Default: state-reset and store-block released one clock after that.
// - Release positions of the three controls are selectable by option.
// - Optionally hold releases until the shared finish line reads high.
// - Optionally pause at a chosen stage until all selected loops lock.
// - Configuration data arrives as frames loaded one after another.
// - Stored frames can be read back with the live user state.
// - Configuration clock starts slow and speeds up after rate bits arrive.
module css_sequencer #(
  parameter int unsigned CLEAR_FRAMES = css_pkg::CLEAR_FRAMES_DFLT,
  parameter int unsigned FRAME_BITS   = css_pkg::FRAME_BITS_DFLT,
  parameter int unsigned FRAME_CNT    = css_pkg::FRAME_CNT_DFLT,
  parameter int unsigned LOCK_W       = 2
) (
  // Clock and reset
  input  wire  logic                  mclk_i,
  input  wire  logic                  reset_i,
  input  wire  logic                  ce_i,
  // Outside pins
  input  wire  logic                  reconfig_req_n_i,
  input  wire  logic                  init_status_i,
  output logic                        init_status_o,
  output logic                        init_status_oe_o,
  input  wire  logic                  finish_line_i,
  output logic                        finish_o,
  output logic                        finish_oe_o,
  output logic                        config_clock_o,
  // Configuration data
  input  wire  logic                  frame_valid_i,
  input  wire  logic [FRAME_BITS-1:0] frame_data_i,
  input  wire  logic                  rate_valid_i,
  input  wire  logic [7:0]            rate_half_i,
  input  wire  css_pkg::css_opt_t     opt_i,
  // Readback
  input  wire  logic                  rb_req_i,
  input  wire  logic [$clog2(FRAME_CNT)-1:0] rb_addr_i,
  input  wire  logic [FRAME_BITS-1:0] user_state_i,
  output logic                        rb_valid_o,
  output logic [FRAME_BITS-1:0]       rb_frame_o,
  output logic [FRAME_BITS-1:0]       rb_user_o,
  // Loops and globals
  input  wire  logic [LOCK_W-1:0]     lock_sel_i,
  input  wire  logic [LOCK_W-1:0]     lock_i,
  output css_pkg::css_glob_t          glob_o
);

  localparam int AW = $clog2(FRAME_CNT);
  localparam int CW = $clog2(CLEAR_FRAMES + 1);

  // ------------------------------------------------------------
  // Sequencer state
  // ------------------------------------------------------------
  css_pkg::css_state_t     state_r, state_nxt;
  logic [CW-1:0]           clr_cnt_r, clr_cnt_nxt;
  logic [AW:0]             frm_cnt_r, frm_cnt_nxt;
  logic [2:0]              stage_r, stage_nxt;
  css_pkg::css_opt_t       opt_r, opt_nxt;
  logic                    init_low_r, init_low_nxt;
  logic                    finish_r, finish_nxt;
  css_pkg::css_glob_t      glob_r, glob_nxt;
  logic [FRAME_BITS-1:0]   mem_r [FRAME_CNT];
  logic                    mem_we;
  logic                    lock_ok;
  logic                    done_ok;

  // Position is reached once the stage count equals or passes it
  function automatic logic reached(input logic [2:0] pos, input logic [2:0] stage);
    reached = (stage >= pos);
  endfunction : reached

  assign lock_ok = ((lock_i & lock_sel_i) == lock_sel_i);
  assign done_ok = !opt_r.wait_done || finish_line_i;
  assign mem_we  = (state_r == css_pkg::CSS_LOAD) && frame_valid_i;

  always_comb
  begin
    state_nxt    = state_r;
    clr_cnt_nxt  = clr_cnt_r;
    frm_cnt_nxt  = frm_cnt_r;
    stage_nxt    = stage_r;
    opt_nxt      = opt_r;
    init_low_nxt = 1'b0;
    finish_nxt   = finish_r;
    glob_nxt     = glob_r;
    case (state_r)
      css_pkg::CSS_CLEAR:
      begin
        init_low_nxt = 1'b1;
        glob_nxt     = '{output_float: 1'b1, state_reset: 1'b1, store_block: 1'b1};
        finish_nxt   = 1'b0;
        if (clr_cnt_r == CW'(CLEAR_FRAMES - 1))
        begin
          init_low_nxt = 1'b0;
          state_nxt    = css_pkg::CSS_HOLD;
        end
        else
        begin
          clr_cnt_nxt = clr_cnt_r + CW'(1);
        end
      end
      css_pkg::CSS_HOLD:
      begin
        // Pin still low means an outside party delays loading
        if (init_status_i && !init_low_r)
        begin
          state_nxt   = css_pkg::CSS_LOAD;
          frm_cnt_nxt = '0;
        end
      end
      css_pkg::CSS_LOAD:
      begin
        if (frame_valid_i)
        begin
          frm_cnt_nxt = frm_cnt_r + (AW+1)'(1);
          if (frm_cnt_r == (AW+1)'(FRAME_CNT - 1))
          begin
            opt_nxt    = opt_i;
            state_nxt  = css_pkg::CSS_START;
            stage_nxt  = '0;
            finish_nxt = 1'b1;
          end
        end
      end
      css_pkg::CSS_START:
      begin
        if (!(opt_r.wait_lock && stage_r == opt_r.lock_stage && !lock_ok)
            && done_ok)
        begin
          stage_nxt = stage_r + 3'h1;
          if (reached(opt_r.pos_float, stage_nxt))
            glob_nxt.output_float = 1'b0;
          if (reached(opt_r.pos_reset, stage_nxt))
            glob_nxt.state_reset = 1'b0;
          if (reached(opt_r.pos_store, stage_nxt))
            glob_nxt.store_block = 1'b0;
          if (stage_r == css_pkg::POS_LAST - 3'h1)
            state_nxt = css_pkg::CSS_RUN;
        end
      end
      default:
      begin
        glob_nxt = '0;
      end
    endcase
    if (!reconfig_req_n_i)
    begin
      state_nxt    = css_pkg::CSS_CLEAR;
      clr_cnt_nxt  = '0;
      init_low_nxt = 1'b1;
      finish_nxt   = 1'b0;
      glob_nxt     = '{output_float: 1'b1, state_reset: 1'b1, store_block: 1'b1};
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      state_r    <= css_pkg::CSS_CLEAR;
      clr_cnt_r  <= '0;
      frm_cnt_r  <= '0;
      stage_r    <= '0;
      opt_r      <= '{pos_float: css_pkg::POS_FLOAT_DFLT, pos_reset: css_pkg::POS_RESET_DFLT,
                      pos_store: css_pkg::POS_STORE_DFLT, default: '0};
      init_low_r <= 1'b1;
      finish_r   <= 1'b0;
      glob_r     <= '{output_float: 1'b1, state_reset: 1'b1, store_block: 1'b1};
    end
    else if (ce_i)
    begin
      state_r    <= state_nxt;
      clr_cnt_r  <= clr_cnt_nxt;
      frm_cnt_r  <= frm_cnt_nxt;
      stage_r    <= stage_nxt;
      opt_r      <= opt_nxt;
      init_low_r <= init_low_nxt;
      finish_r   <= finish_nxt;
      glob_r     <= glob_nxt;
    end
  end

  // ------------------------------------------------------------
  // Frame store and readback
  // ------------------------------------------------------------
  logic                  rb_valid_r;
  logic [FRAME_BITS-1:0] rb_frame_r, rb_user_r;

  always_ff @(posedge mclk_i)
  begin
    if (ce_i && mem_we)
      mem_r[frm_cnt_r[AW-1:0]] <= frame_data_i;
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      rb_valid_r <= 1'b0;
      rb_frame_r <= '0;
      rb_user_r  <= '0;
    end
    else if (ce_i)
    begin
      rb_valid_r <= rb_req_i;
      if (rb_req_i)
      begin
        rb_frame_r <= mem_r[rb_addr_i];
        rb_user_r  <= user_state_i;
      end
    end
  end

  // ------------------------------------------------------------
  // Configuration clock
  // ------------------------------------------------------------
  // Rate only rises: a slower request is ignored, as the source may not keep up
  logic [7:0] half_r;
  logic [7:0] div_r;
  logic       config_clock_r;

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      half_r <= 8'(css_pkg::SLOW_HALF_CYC);
      div_r  <= 8'h00;
      config_clock_r <= 1'b0;
    end
    else if (ce_i)
    begin
      if (rate_valid_i && rate_half_i != 8'h00 && rate_half_i < half_r)
        half_r <= rate_half_i;
      if (div_r + 8'h01 >= half_r)
      begin
        div_r  <= 8'h00;
        config_clock_r <= ~config_clock_r;
      end
      else
      begin
        div_r <= div_r + 8'h01;
      end
    end
  end

  // ------------------------------------------------------------
  // Pin outputs
  // ------------------------------------------------------------
  assign init_status_o    = 1'b0;
  assign init_status_oe_o = init_low_r;
  assign finish_o         = finish_r;
  assign finish_oe_o      = 1'b1;
  assign config_clock_o   = config_clock_r;
  assign glob_o           = glob_r;
  assign rb_valid_o       = rb_valid_r;
  assign rb_frame_o       = rb_frame_r;
  assign rb_user_o        = rb_user_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  float_after_finish_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    $rose(finish_r) && opt_r.pos_float == css_pkg::POS_FLOAT_DFLT && !opt_r.wait_lock
    && !opt_r.wait_done && ce_i && reconfig_req_n_i
    |-> glob_r.output_float ##1 !glob_r.output_float)
    else $error("output float not released one clock after finish");
  reset_after_float_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    $fell(glob_r.output_float) && opt_r.pos_reset == 3'h2 && opt_r.pos_store == 3'h2
    && opt_r.pos_float == 3'h1 && ce_i && done_ok && !opt_r.wait_lock
    |=> !glob_r.state_reset && !glob_r.store_block)
    else $error("state reset or store not released after float");
  init_low_clear_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    state_r == css_pkg::CSS_CLEAR |-> init_status_oe_o)
    else $error("status pin not pulled low while clearing");
  init_never_high_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    !init_status_o)
    else $error("status pin driven high");
  hold_wait_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    state_r == css_pkg::CSS_HOLD && !init_status_i && reconfig_req_n_i
    |=> state_r == css_pkg::CSS_HOLD)
    else $error("loading entered while status pin low");
  restart_clear_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    !reconfig_req_n_i && ce_i |=> state_r == css_pkg::CSS_CLEAR && !finish_r)
    else $error("request did not restart clearing");
  finish_only_late_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    finish_r |-> state_r inside {css_pkg::CSS_START, css_pkg::CSS_RUN})
    else $error("finish high before loading complete");
  globals_held_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    state_r inside {css_pkg::CSS_HOLD, css_pkg::CSS_LOAD}
    |-> glob_r.output_float && glob_r.state_reset && glob_r.store_block)
    else $error("global control released before start-up");
  lock_pause_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    state_r == css_pkg::CSS_START && opt_r.wait_lock && stage_r == opt_r.lock_stage
    && !lock_ok && reconfig_req_n_i |=> $stable(stage_r))
    else $error("start-up advanced without lock");
  sync_pause_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    state_r == css_pkg::CSS_START && opt_r.wait_done && !finish_line_i
    && reconfig_req_n_i |=> $stable(glob_r))
    else $error("release while shared finish line low");

endmodule : css_sequencer
`default_nettype wire

// ---- css_far_end.sv ----
`default_nettype none
module css_far_end (
  // Clock
  input  wire logic mclk_i,
  // Bench commands
  input  wire logic hold_i,
  input  wire logic peer_busy_i,
  input  wire logic restart_i,
  // Pins
  output logic      init_hold_oe_o,
  output logic      peer_done_oe_o,
  output logic      reconfig_req_n_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Starts idle so the request pin is high from the first cycle
  logic [1:0] pulse_r = 2'h0;

  // Open-drain pull only, the status pin is never driven high
  always_ff @(posedge mclk_i) init_hold_oe_o <= hold_i;
  // A slower peer keeps the shared finish line low
  always_ff @(posedge mclk_i) peer_done_oe_o <= peer_busy_i;
  // Request held low two cycles, then released high
  always_ff @(posedge mclk_i)
  begin
    if (restart_i)
      pulse_r <= 2'h2;
    else if (pulse_r != 2'h0)
      pulse_r <= pulse_r - 2'h1;
  end
  assign reconfig_req_n_o = (pulse_r == 2'h0);
endmodule : css_far_end
`default_nettype wire

// ---- config_sequence_startup_tb.sv ----
`default_nettype none
module config_sequence_startup_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FC = 4;
  localparam int CF = 4;
  logic               mclk_i      = 1'b0;
  logic               reset_i     = 1'b1;
  logic               hold        = 1'b0;
  logic               busy        = 1'b0;
  logic               restart     = 1'b0;
  logic               fv          = 1'b0;
  logic               rv          = 1'b0;
  logic               rbq         = 1'b0;
  logic [31:0]        fd          = 32'h0;
  logic [31:0]        us          = 32'h0;
  logic [7:0]         rh          = 8'h0;
  logic [1:0]         ra          = 2'h0;
  logic [1:0]         lsel        = 2'h0;
  logic [1:0]         lck         = 2'h0;
  css_pkg::css_opt_t  opt         = '0;
  logic [31:0]        seed        = 32'h0001169A;
  logic               hold_oe, busy_oe, req_n, ist_o, ist_oe, fin, fin_oe, config_clock, rbv;
  logic [31:0]        rbf, rbu;
  css_pkg::css_glob_t glob;
  logic [31:0]        q[$];
  int                 miscompares = 0;
  int                 comparisons = 0;
  // Wired levels: status pin pulled up, finish line wire-AND
  wire logic init_lvl = ~(ist_oe | hold_oe);
  wire logic fin_line = (fin | ~fin_oe) & ~busy_oe;

  always #2 mclk_i = ~mclk_i;

  css_far_end css_far_end_i (.mclk_i(mclk_i), .hold_i(hold), .peer_busy_i(busy),
    .restart_i(restart), .init_hold_oe_o(hold_oe), .peer_done_oe_o(busy_oe),
    .reconfig_req_n_o(req_n));

  css_sequencer #(.CLEAR_FRAMES(CF), .FRAME_CNT(FC)) css_sequencer_i (.mclk_i(mclk_i),
    .reset_i(reset_i), .ce_i(1'b1), .reconfig_req_n_i(req_n), .init_status_i(init_lvl),
    .init_status_o(ist_o), .init_status_oe_o(ist_oe), .finish_line_i(fin_line),
    .finish_o(fin), .finish_oe_o(fin_oe), .config_clock_o(config_clock), .frame_valid_i(fv),
    .frame_data_i(fd), .rate_valid_i(rv), .rate_half_i(rh), .opt_i(opt), .rb_req_i(rbq),
    .rb_addr_i(ra), .user_state_i(us), .rb_valid_o(rbv), .rb_frame_o(rbf),
    .rb_user_o(rbu), .lock_sel_i(lsel), .lock_i(lck), .glob_o(glob));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic chk_bit(input logic g, input logic e);
    comparisons++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_bit

  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_word

  task automatic end_sim();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim

  task automatic load(input css_pkg::css_opt_t o);
    logic [31:0] d;
    q.delete();
    for (int i = 0; i < FC; i++)
    begin
      d = rnd();
      q.push_back(d);
      @(posedge mclk_i);
      fv  <= 1'b1;
      fd  <= d;
      opt <= o;
      @(negedge mclk_i);
      chk_bit(fin, 1'b0);
    end
    @(posedge mclk_i);
    fv <= 1'b0;
  endtask : load

  // Cycle n after finish rises: a control is released once n reaches its position
  task automatic walk(input int pf, input int pr, input int ps);
    int n;
    for (n = 0; n < 8 && fin !== 1'b1; n++) @(negedge mclk_i);
    chk_bit(fin, 1'b1);
    for (n = 0; n < 8; n++)
    begin
      chk_bit(glob.output_float, n < pf);
      chk_bit(glob.state_reset, n < pr);
      chk_bit(glob.store_block, n < ps);
      @(negedge mclk_i);
    end
  endtask : walk

  task automatic reload();
    int n;
    @(posedge mclk_i);
    restart <= 1'b1;
    @(posedge mclk_i);
    restart <= 1'b0;
    repeat (3) @(negedge mclk_i);
    chk_bit(ist_oe, 1'b1);
    chk_bit(fin, 1'b0);
    chk_word(32'(glob), 32'h7);
    for (n = 0; n < 60 && init_lvl !== 1'b1; n++) @(negedge mclk_i);
    chk_bit(init_lvl, 1'b1);
    repeat (3) @(negedge mclk_i);
  endtask : reload

  task automatic meas(input int e);
    int n;
    logic c;
    c = config_clock;
    for (n = 0; n < 300 && config_clock === c; n++) @(negedge mclk_i);
    c = config_clock;
    for (n = 0; n < 300 && config_clock === c; n++) @(negedge mclk_i);
    chk_word(32'(n), 32'(e));
  endtask : meas

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial
  begin
    int n;
    logic [31:0] u;
    css_pkg::css_opt_t o;
    repeat (12) @(posedge mclk_i);
    reset_i <= 1'b0;
    hold    <= 1'b1;
    for (n = 0; n < CF - 1; n++)
    begin
      @(negedge mclk_i);
      chk_bit(ist_oe, 1'b1);
      chk_bit(ist_o | ~fin_oe, 1'b0);
      chk_word(32'(glob), 32'h7);
    end
    for (n = 0; n < 20 && ist_oe !== 1'b0; n++) @(negedge mclk_i);
    chk_bit(ist_oe, 1'b0);
    meas(css_pkg::SLOW_HALF_CYC);
    o = '{css_pkg::POS_FLOAT_DFLT, css_pkg::POS_RESET_DFLT, css_pkg::POS_STORE_DFLT,
          1'b0, 1'b0, 3'h0};
    load(o);
    chk_bit(init_lvl, 1'b0);
    $display("clear and hold done");
    hold <= 1'b0;
    for (n = 0; n < 20 && init_lvl !== 1'b1; n++) @(negedge mclk_i);
    repeat (3) @(negedge mclk_i);
    load(o);
    walk(1, 2, 2);
    for (n = 0; n < FC; n++)
    begin
      u = rnd();
      @(posedge mclk_i);
      rbq <= 1'b1;
      ra  <= n[1:0];
      us  <= u;
      @(posedge mclk_i);
      rbq <= 1'b0;
      @(negedge mclk_i);
      chk_bit(rbv, 1'b1);
      chk_word(rbf, q[n]);
      chk_word(rbu, u);
    end
    $display("default start-up and readback done");
    for (n = 0; n < 3; n++)
    begin
      o = '{3'(3 - n), 3'(1 + 3 * n), 3'(5 + n), 1'b0, 1'b0, 3'h0};
      reload();
      load(o);
      walk(3 - n, 1 + 3 * n, 5 + n);
    end
    $display("ordered start-up done");
    for (n = 0; n < 2; n++)
    begin
      o = '{3'h1, 3'h2, 3'h2, n == 0, n == 1, 3'h1};
      busy <= (n == 0);
      lsel <= 2'h3;
      lck  <= 2'h1;
      reload();
      load(o);
      repeat (12) @(negedge mclk_i);
      chk_bit(glob.state_reset, 1'b1);
      // Shared-line wait holds every release; lock pause at stage 1 follows the float release
      chk_word(32'(glob), (n == 0) ? 32'h7 : 32'h3);
      @(posedge mclk_i);
      busy <= 1'b0;
      lck  <= 2'h3;
      repeat (12) @(negedge mclk_i);
      chk_word(32'(glob), 32'h0);
    end
    $display("stalled start-up done");
    @(posedge mclk_i);
    rv <= 1'b1;
    rh <= 8'h0A;
    @(posedge mclk_i);
    rv <= 1'b0;
    meas(10);
    meas(10);
    @(posedge mclk_i);
    rv <= 1'b1;
    rh <= 8'h14;
    @(posedge mclk_i);
    rv <= 1'b0;
    meas(10);
    meas(10);
    $display("clock rate done");
    end_sim();
  end

  initial
  begin
    repeat (20000) @(posedge mclk_i);
    miscompares++;
    end_sim();
  end
endmodule : config_sequence_startup_tb
`default_nettype wire
